//--- sarpc_pkg.sv
// Package with constants and types shared by the converter control port.
`default_nettype none
package sarpc_pkg;
  // Control word field positions.
  localparam int unsigned CW_POWER_HI_BIT = 7;
  localparam int unsigned CW_POWER_LO_BIT = 6;
  localparam int unsigned CW_ACQ_BIT = 5;
  localparam int unsigned CW_SGL_BIT = 4;
  localparam int unsigned CW_UNI_BIT = 3;
  localparam int unsigned CW_ADDR_MSB = 2;
  localparam int unsigned CW_ADDR_LSB = 0;
  localparam int unsigned CW_WIDTH = 8;
  localparam int unsigned RESULT_WIDTH = 10;
  localparam int unsigned HI_BITS = 2;

  // Power select encodings.
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_NORM_INT = 2'h2;
  localparam logic [1:0] PWR_NORM_EXT = 2'h3;

  // Values after reset.
  localparam logic [7:0] CW_RESET = 8'hc8;
  localparam logic CLK_EXT_RESET = 1'b1;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
  localparam logic [9:0] BIPOLAR_FLIP = 10'h200;

  // Timing.
  localparam int unsigned CORE_CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_TICKS = 13;
  localparam int unsigned SAR_TRIALS = 10;
  localparam int unsigned ACQ_EXT_TICKS = 3;
  localparam int unsigned INT_CONV_TIME_NS = 3600;
  localparam int unsigned INT_ACQ_TIME_NS = 1000;
  localparam int unsigned INT_TICK_CYCLES_I =
    INT_CONV_TIME_NS / (CONV_TICKS * CORE_CLK_PERIOD_NS);
  localparam int unsigned INT_ACQ_CYCLES_I = INT_ACQ_TIME_NS / CORE_CLK_PERIOD_NS;
  localparam logic [7:0] INT_TICK_CYCLES = 8'(INT_TICK_CYCLES_I);
  localparam logic [7:0] INT_ACQ_CYCLES = 8'(INT_ACQ_CYCLES_I);
  localparam logic [7:0] ACQ_EXT_COUNT = 8'(ACQ_EXT_TICKS);
  localparam logic [3:0] CONV_LAST_TICK = 4'(CONV_TICKS - 1);
  localparam logic [3:0] SAR_LAST_TRIAL = 4'(SAR_TRIALS - 1);

  // Synchroniser width: data bus plus six control pins.
  localparam int unsigned SYNC_WIDTH = 14;

  typedef enum logic [2:0] {
    SARPC_IDLE,
    SARPC_ACQ_INT,
    SARPC_ACQ_EXT,
    SARPC_CONV
  } sarpc_state_t;
endpackage
`default_nettype wire

//--- sarpc_pin_if.sv
// Interface carrying synchronised pins and the conversion tick inside the block.
`timescale 1ns/1ps
`default_nettype none
interface sarpc_pin_if;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic high_byte_select;
  logic conv_clk;
  logic cmp_above;
  logic [7:0] data;
  logic clk_ext;
  logic tick_run;
  logic tick;

  modport sync (output cs_n, wr_n, rd_n, high_byte_select, conv_clk, cmp_above, data);
  modport tickgen (input cs_n, conv_clk, clk_ext, tick_run, output tick);
  modport ctrl (input cs_n, wr_n, rd_n, high_byte_select, cmp_above, data, tick,
                output clk_ext, tick_run);
endinterface
`default_nettype wire

//--- sarpc_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module sarpc_sync
  import sarpc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Raw pins.
  input wire logic [sarpc_pkg::SYNC_WIDTH-1:0] pins,
  // Synchronised values.
  sarpc_pin_if.sync pin
);
  typedef struct packed {
    logic [SYNC_WIDTH-1:0] s1;
    logic [SYNC_WIDTH-1:0] s2;
    logic [SYNC_WIDTH-1:0] s3;
    logic [SYNC_WIDTH-1:0] val;
  } sarpc_sync_t;

  // Strobes idle high after reset.
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 14'h0f00;

  sarpc_sync_t st_q;
  sarpc_sync_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < SYNC_WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '{s1: SYNC_RESET, s2: SYNC_RESET, s3: SYNC_RESET, val: SYNC_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign pin.data = st_q.val[7:0];
  assign pin.cs_n = st_q.val[8];
  assign pin.wr_n = st_q.val[9];
  assign pin.rd_n = st_q.val[10];
  assign pin.high_byte_select = st_q.val[11];
  assign pin.conv_clk = st_q.val[12];
  assign pin.cmp_above = st_q.val[13];
endmodule // sarpc_sync
`default_nettype wire

//--- sarpc_tick.sv
// Conversion tick source: external clock falling edges or an internal divider.
`timescale 1ns/1ps
`default_nettype none
module sarpc_tick
  import sarpc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Pins and tick.
  sarpc_pin_if.tickgen pin
);
  typedef struct packed {
    logic [7:0] div;
    logic cclk_prev;
    logic tick;
  } sarpc_tick_t;

  sarpc_tick_t st_q;
  sarpc_tick_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    st_d.cclk_prev = pin.conv_clk;
    if (!pin.tick_run) begin
      st_d.div = 8'h00;
    end else if (pin.clk_ext) begin
      // The external clock counts only while the chip is selected.
      st_d.tick = st_q.cclk_prev && !pin.conv_clk && !pin.cs_n;
    end else if (st_q.div == INT_TICK_CYCLES - 8'h01) begin
      st_d.div = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '{div: 8'h00, cclk_prev: 1'b0, tick: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pin.tick = st_q.tick;
endmodule // sarpc_tick
`default_nettype wire

//--- sarpc_top.sv
// Control and readout logic of a 10-bit successive-approximation converter port.
//
// Functional notes
// - Completion flag goes low when a conversion ends and data is ready.
// - Completion flag returns high on the first read or a new control word.
// - Bits 7:6 at 00 or 01 select full power-down or standby.
// - Bits 7:6 at 10 select normal operation on the internal clock.
// - Bits 7:6 at 11 select normal operation on the external clock.
// - Power-down words keep the last selected clock source.
// - After reset the external clock source is selected.
// - Bit 5 picks internally (0) or externally (1) timed acquisition.
// - Bit 4 picks single-ended (1) or channel-pair differential (0) input.
// - Bit 3 picks unipolar (1) or bipolar (0) conversion.
// - Bits 2:0 address the channel or channel pair converted.
// - Chip select high ignores clock, write and read and floats the bus.
// - One three-state bus carries control words in and results out.
// - All eight data lines are captured on a selected write.
// - Results are straight binary unipolar, two's complement bipolar.
// - High-byte select low drives the lower eight result bits.
// - High-byte select high drives top bits, upper lines zero or sign.
// - Every conversion lasts thirteen conversion-clock cycles.
// - A control word during conversion aborts it and starts acquisition.
// - Internal acquisition lasts three external ticks or about one microsecond.
// - External acquisition ends on a second write with bit 5 clear, same address.
`timescale 1ns/1ps
`default_nettype none
module sarpc_top
  import sarpc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Host strobes.
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  input wire logic conv_clk,
  // Shared data bus.
  input wire logic [sarpc_pkg::CW_WIDTH-1:0] data_in,
  output logic [sarpc_pkg::CW_WIDTH-1:0] data_out,
  output logic data_oe,
  // Completion flag.
  output logic done_n,
  // Analog front end.
  input wire logic cmp_above,
  output logic [sarpc_pkg::RESULT_WIDTH-1:0] dac_code,
  output logic track,
  output logic converting,
  output logic [1:0] power_select,
  output logic clk_ext_mode,
  output logic [2:0] channel_addr,
  output logic single_ended_select,
  output logic unipolar_select
);
  import sarpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and tick source.

  sarpc_pin_if pin ();

  sarpc_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pins({cmp_above, conv_clk, high_byte_select, rd_n, wr_n, cs_n, data_in}),
    .pin(pin.sync)
  );

  sarpc_tick u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin(pin.tickgen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    sarpc_state_t state;
    logic [7:0] cw;
    logic clk_ext;
    logic [7:0] cnt;
    logic [3:0] tick_cnt;
    logic [9:0] sar;
    logic [9:0] result;
    logic result_uni;
    logic done_n;
    logic wr_prev;
    logic rd_prev;
    logic [7:0] dout;
    logic oe;
    logic track;
    logic busy;
  } sarpc_ctrl_t;

  sarpc_ctrl_t st_q;
  sarpc_ctrl_t st_d;

  logic wr_done;
  logic rd_start;
  logic reading;
  logic [1:0] new_pwr;
  logic [7:0] hi_byte;
  logic [9:0] trial;
  logic [3:0] bit_idx;

  // Strobes count only while the chip is selected.
  assign wr_done = !st_q.wr_prev && pin.wr_n && !pin.cs_n;
  assign rd_start = st_q.rd_prev && !pin.rd_n && !pin.cs_n;
  assign reading = !pin.cs_n && !pin.rd_n && pin.wr_n;
  assign new_pwr = pin.data[CW_POWER_HI_BIT:CW_POWER_LO_BIT];

  assign pin.clk_ext = st_q.clk_ext;
  // The divider rests during internally timed acquisition on the internal clock, so the first
  // conversion tick leaves the synchronised comparator time to settle on the first trial.
  assign pin.tick_run = (st_q.state == SARPC_CONV)
                        || (st_q.state == SARPC_ACQ_INT && st_q.clk_ext);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    st_d = st_q;
    st_d.wr_prev = pin.wr_n;
    st_d.rd_prev = pin.rd_n;
    bit_idx = 4'(SAR_LAST_TRIAL - st_q.tick_cnt);
    trial = st_q.sar;
    hi_byte = 8'h00;

    case (st_q.state)
      SARPC_ACQ_INT: begin
        if (st_q.clk_ext ? pin.tick : 1'b1) begin
          st_d.cnt = st_q.cnt + 8'h01;
        end
        if (st_q.clk_ext ? (pin.tick && st_q.cnt == ACQ_EXT_COUNT - 8'h01)
                         : (st_q.cnt == INT_ACQ_CYCLES - 8'h01)) begin
          st_d.state = SARPC_CONV;
          st_d.track = 1'b0;
          st_d.tick_cnt = 4'h0;
          st_d.sar = SAR_FIRST_TRIAL;
        end
      end
      SARPC_CONV: begin
        if (pin.tick) begin
          st_d.tick_cnt = st_q.tick_cnt + 4'h1;
          if (st_q.tick_cnt <= SAR_LAST_TRIAL) begin
            // Keep the trial bit if the input lies above it, then try the next bit.
            trial[bit_idx] = pin.cmp_above;
            if (bit_idx != 4'h0) begin
              trial[bit_idx - 4'h1] = 1'b1;
            end
            st_d.sar = trial;
          end
          if (st_q.tick_cnt == CONV_LAST_TICK) begin
            st_d.state = SARPC_IDLE;
            st_d.result_uni = st_q.cw[CW_UNI_BIT];
            // Bipolar compares in offset binary; flipping the top bit gives two's
            // complement.
            st_d.result = st_q.cw[CW_UNI_BIT] ? st_q.sar
                                              : (st_q.sar ^ BIPOLAR_FLIP);
            st_d.track = 1'b1;
          end
        end
      end
      SARPC_ACQ_EXT, SARPC_IDLE: begin
      end
      default: begin
        st_d.state = SARPC_IDLE;
      end
    endcase

    // Completion flag: a read start or a write clears it, completion below wins over a read.
    if (rd_start || wr_done) begin
      st_d.done_n = 1'b1;
    end

    if (wr_done) begin
      st_d.cw = pin.data;
      st_d.cnt = 8'h00;
      st_d.track = 1'b1;
      if (new_pwr == PWR_NORM_INT || new_pwr == PWR_NORM_EXT) begin
        st_d.clk_ext = new_pwr[0];
      end
      if (st_q.state == SARPC_ACQ_EXT && !pin.data[CW_ACQ_BIT]
          && pin.data[CW_ADDR_MSB:CW_ADDR_LSB] == st_q.cw[CW_ADDR_MSB:CW_ADDR_LSB]) begin
        // Second write ends acquisition and holds the sample now.
        st_d.state = SARPC_CONV;
        st_d.track = 1'b0;
        st_d.tick_cnt = 4'h0;
        st_d.sar = SAR_FIRST_TRIAL;
      end else if (pin.data[CW_ACQ_BIT]) begin
        st_d.state = SARPC_ACQ_EXT;
      end else begin
        st_d.state = SARPC_ACQ_INT;
      end
    end

    if (st_q.state == SARPC_CONV && pin.tick && st_q.tick_cnt == CONV_LAST_TICK
        && !wr_done) begin
      st_d.done_n = 1'b0;
    end

    // Read data path; the result register only changes on completion.
    hi_byte = {{6{st_q.result_uni ? 1'b0 : st_q.result[RESULT_WIDTH-1]}},
               st_q.result[RESULT_WIDTH-1:RESULT_WIDTH-HI_BITS]};
    st_d.dout = pin.high_byte_select ? hi_byte : st_q.result[7:0];
    st_d.oe = reading;
    st_d.busy = (st_d.state == SARPC_CONV);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '{state: SARPC_IDLE, cw: CW_RESET, clk_ext: CLK_EXT_RESET, cnt: 8'h00,
                tick_cnt: 4'h0, sar: RESULT_RESET, result: RESULT_RESET,
                result_uni: 1'b1, done_n: 1'b1, wr_prev: 1'b1, rd_prev: 1'b1,
                dout: 8'h00, oe: 1'b0, track: 1'b1, busy: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign data_out = st_q.dout;
  assign data_oe = st_q.oe;
  assign done_n = st_q.done_n;
  assign dac_code = st_q.sar;
  assign track = st_q.track;
  assign converting = st_q.busy;
  assign power_select = st_q.cw[CW_POWER_HI_BIT:CW_POWER_LO_BIT];
  assign clk_ext_mode = st_q.clk_ext;
  assign channel_addr = st_q.cw[CW_ADDR_MSB:CW_ADDR_LSB];
  assign single_ended_select = st_q.cw[CW_SGL_BIT];
  assign unipolar_select = st_q.cw[CW_UNI_BIT];
endmodule // sarpc_top
`default_nettype wire

//--- sarpc_props.sv
// Concurrent checks on the converter control port pins.
`timescale 1ns/1ps
`default_nettype none
module sarpc_props
  import sarpc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Host pins.
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  // Watched outputs.
  input wire logic [sarpc_pkg::CW_WIDTH-1:0] data_out,
  input wire logic data_oe,
  input wire logic done_n,
  input wire logic converting,
  input wire logic [1:0] power_select,
  input wire logic clk_ext_mode,
  input wire logic unipolar_select
);
  localparam int ConvMin = 300;
  localparam int ConvMax = 380;
  logic [9:0] conv_len_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      conv_len_q <= 10'h000;
    end else if ($rose(converting)) begin
      conv_len_q <= 10'h001;
    end else if (converting && conv_len_q != 10'h3ff) begin
      conv_len_q <= conv_len_q + 10'h001;
    end
  end
  sequence hi_read_uni;
    (data_oe && high_byte_select && unipolar_select)[*6];
  endsequence
  sequence hi_read_bip;
    (data_oe && high_byte_select && !unipolar_select)[*6];
  endsequence
  ////////////////////////////////////////
  float_deselected_a: assert property (cs_n[*6] |-> !data_oe)
    else $error("bus driven while deselected");
  drive_on_read_a: assert property (rd_n[*6] |-> !data_oe)
    else $error("bus driven without read");
  hi_zero_fill_a: assert property (hi_read_uni |-> data_out[7:2] == 6'h00)
    else $error("upper lines not zero");
  hi_sign_fill_a: assert property (hi_read_bip |-> data_out[7:2] == {6{data_out[1]}})
    else $error("upper lines not sign");
  ext_follows_a: assert property (power_select[1] |-> clk_ext_mode == power_select[0])
    else $error("clock source mismatch");
  mode_kept_a: assert property (!power_select[1] |-> $stable(clk_ext_mode))
    else $error("clock source changed in power-down");
  done_from_conv_a: assert property ($fell(done_n) |->
    $past(converting) || $past(converting, 2) || $past(converting, 3))
    else $error("flag without conversion");
  flag_holds_a: assert property ($fell(done_n) |=> !done_n [*3])
    else $error("flag dropped early");
  conv_time_a: assert property ($fell(done_n) && !clk_ext_mode |->
    conv_len_q >= ConvMin && conv_len_q <= ConvMax)
    else $error("conversion length wrong");
endmodule // sarpc_props
`default_nettype wire

//--- sarpc_front_model.sv
// Comparator and external conversion clock seen by the converter port.
`timescale 1ns/1ps
`default_nettype none
module sarpc_front_model
  import sarpc_pkg::*;
(
  // Clock and stimulus.
  input wire logic core_clk,
  input wire logic clk_run,
  input wire logic [sarpc_pkg::RESULT_WIDTH-1:0] vin_code,
  // Converter side.
  input wire logic [sarpc_pkg::RESULT_WIDTH-1:0] dac_code,
  output logic cmp_above,
  output logic conv_clk
);
  logic [3:0] div_q = 4'h0;
  logic ph_q = 1'b0;
  ////////////////////////////////////////
  // The input sits half a step above its code, so equality counts as above.
  assign cmp_above = (vin_code >= dac_code);
  assign conv_clk = ph_q;
  always @(posedge core_clk) begin
    if (!clk_run) begin
      div_q <= 4'h0;
      ph_q <= 1'b0;
    end else if (div_q == 4'hb) begin
      div_q <= 4'h0;
      ph_q <= ~ph_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
endmodule // sarpc_front_model
`default_nettype wire

//--- sarpc_bench.sv
// Self-checking bench for the converter control port.
`timescale 1ns/1ps
`default_nettype none
module sarpc_bench;
  import sarpc_pkg::*;
  logic core_clk, resetn, cs_n, wr_n, rd_n, hbs, clk_run, hold_cs, ext_exp;
  logic data_oe, done_n, cmp_above, conv_clk, track, converting, clk_ext_mode, sgl, uni;
  logic [7:0] data_in, data_out;
  logic [9:0] vin, dac_code;
  logic [1:0] power_select;
  logic [2:0] channel_addr;
  int fails, n_checks, t;
  sarpc_top u_sarpc_top (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .high_byte_select(hbs), .conv_clk(conv_clk), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .done_n(done_n), .cmp_above(cmp_above),
    .dac_code(dac_code), .track(track), .converting(converting), .power_select(power_select),
    .clk_ext_mode(clk_ext_mode), .channel_addr(channel_addr), .single_ended_select(sgl),
    .unipolar_select(uni));
  sarpc_front_model u_sarpc_front_model (.core_clk(core_clk), .clk_run(clk_run),
    .vin_code(vin), .dac_code(dac_code), .cmp_above(cmp_above), .conv_clk(conv_clk));
  ////////////////////////////////////////
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] cw);
    cs_n <= 1'b0;
    data_in <= cw;
    cyc(6);
    wr_n <= 1'b0;
    cyc(6);
    wr_n <= 1'b1;
    cyc(6);
    cs_n <= ~hold_cs;
    check(10'(done_n), 10'h1, "flag after write");
  endtask
  task automatic rd(input logic hb, input logic [7:0] exp);
    cs_n <= 1'b0;
    hbs <= hb;
    rd_n <= 1'b0;
    for (t = 0; t < 20 && data_oe !== 1'b1; t++) cyc(1);
    cyc(1);
    check(10'(data_out), 10'(exp), "read byte");
    check(10'(done_n), 10'h1, "flag after read");
    rd_n <= 1'b1;
    cyc(6);
    cs_n <= ~hold_cs;
    cyc(6);
  endtask
  task automatic convert(input logic [7:0] cw, input logic [9:0] v, input int acq);
    int n;
    int cv;
    logic [9:0] res;
    cv = CONV_TICKS * INT_TICK_CYCLES_I;
    res = cw[3] ? v : v ^ BIPOLAR_FLIP;
    if (cw[7]) begin
      ext_exp = cw[6];
    end
    vin <= v;
    wr(cw);
    n = {power_select, sgl, uni, channel_addr};
    check(10'(n), 10'({cw[7:6], cw[4:0]}), "fields");
    check(10'(clk_ext_mode), 10'(ext_exp), "clock mode");
    for (n = 0; n < 3000 && done_n !== 1'b0; n++) cyc(1);
    check(10'(done_n), 10'h0, "flag at end");
    if (acq >= 0) begin
      check(10'(n > acq + cv - 40 && n < acq + cv + 10), 10'h1, "time");
    end
    rd(1'b0, res[7:0]);
    rd(1'b1, cw[3] ? {6'h00, res[9:8]} : {{6{res[9]}}, res[9:8]});
    rd(1'b0, res[7:0]);
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    $display("unexpected at %0t: timeout", $time);
    wrap_up();
  end
  initial begin
    resetn = 1'b0;
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    hbs = 1'b0;
    data_in = 8'h00;
    vin = 10'h000;
    clk_run = 1'b0;
    hold_cs = 1'b0;
    ext_exp = 1'b1;
    fails = 0;
    n_checks = 0;
    cyc(12);
    resetn <= 1'b1;
    cyc(4);
    check(10'({clk_ext_mode, power_select, done_n, data_oe}), 10'h1e, "reset");
    wr_n <= 1'b0;
    cyc(6);
    wr_n <= 1'b1;
    cyc(8);
    check(10'({power_select, channel_addr}), 10'h18, "deselected write");
    convert(8'h9b, 10'h2a5, INT_ACQ_CYCLES_I);
    convert(8'h84, 10'h0a5, INT_ACQ_CYCLES_I);
    convert(8'h1e, 10'h3ff, INT_ACQ_CYCLES_I);
    convert(8'h50, 10'h000, INT_ACQ_CYCLES_I);
    vin <= 10'h155;
    wr(8'h9b);
    cyc(200);
    check(10'({converting, track}), 10'h2, "sample held");
    convert(8'h9a, 10'h0cc, INT_ACQ_CYCLES_I);
    wr(8'hab);
    cyc(300);
    check(10'({done_n, converting, track}), 10'h5, "held in acquisition");
    convert(8'h8b, 10'h111, 0);
    hold_cs <= 1'b1;
    clk_run <= 1'b1;
    cyc(1);
    convert(8'hc9, 10'h1c3, -1);
    convert(8'h05, 10'h07e, -1);
    clk_run <= 1'b0;
    hold_cs <= 1'b0;
    cs_n <= 1'b1;
    cyc(6);
    wrap_up();
  end
endmodule // sarpc_bench
bind sarpc_top sarpc_props u_sarpc_props (.core_clk(core_clk), .resetn(resetn),
  .cs_n(cs_n), .rd_n(rd_n), .high_byte_select(high_byte_select), .data_out(data_out),
  .data_oe(data_oe), .done_n(done_n), .converting(converting),
  .power_select(power_select), .clk_ext_mode(clk_ext_mode),
  .unipolar_select(unipolar_select));
`default_nettype wire
